//--- hw/hv_params.svh
// named offsets, field positions, reset values and timing counts
// assumes a 100 MHz system clock and a byte-addressed 32-bit register port
`ifndef HV_PARAMS_SVH
`define HV_PARAMS_SVH
// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define HV_CMD_OFS 32'hffff_0804
`define HV_DAT_OFS 32'hffff_080c
`define HV_IRQ_STAT_OFS 32'hffff_0810
`define HV_IRQ_CLR_OFS 32'hffff_0814
`define HV_IRQ_EN_OFS 32'hffff_0818
// ----------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------
`define HV_CMD_RST 8'h00
`define HV_DAT_RST 12'h000
`define HV_IRQ_RST 2'h0
`define HV_BUSY_BIT 0
`define HV_RXOK_BIT 1
`define HV_TXOK_BIT 2
`define HV_EV_DONE 0
`define HV_EV_FAIL 1
`define HV_TAG_HI 11
`define HV_TAG_LO 8
// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define HV_SYS_KHZ 100000
`define HV_LINK_KHZ 2560
`define HV_HALF_CYC ((`HV_SYS_KHZ) / (2 * `HV_LINK_KHZ))
`define HV_LATENCY_NS 10000
`define HV_LATENCY_CYC ((`HV_LATENCY_NS) * (`HV_SYS_KHZ) / 1000000)
// ----------------------------------------------------------------
// framing
// ----------------------------------------------------------------
`define HV_TX_BITS 13
`define HV_RX_RD_BITS 9
`define HV_RX_WR_BITS 1
`define HV_START_BIT 1'b1
`endif

//--- hw/hv_pkg.sv
// types shared by the indirect register interface
// assumes hv_params.svh supplies the numeric constants
package hv_pkg;
  // ----------------------------------------------------------------
  // command codes
  // ----------------------------------------------------------------
  typedef enum logic [7:0] {
    CMD_RD_CFG0 = 8'h00,
    CMD_RD_CFG1 = 8'h01,
    CMD_RD_STAT = 8'h02,
    CMD_RD_MON = 8'h03,
    CMD_WR_CFG0 = 8'h08,
    CMD_WR_CFG1 = 8'h09
  } cmd_e;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_XFER = 2'b01,
    ST_DONE = 2'b11
  } phase_e;
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } bus_req_s;
  typedef struct packed {
    logic sclk;
    logic sdat_out;
    logic sdat_oe_n;
  } link_out_s;
endpackage : hv_pkg

//--- hw/hv_indirect_register_interface.sv
// command interpreter for four indirect registers on a companion die
// assumes a single 100 MHz clock; the far end follows the serial framing below
//
// Overview of operation
// - a command byte requests read or write of one of four 8-bit registers
// - 0x00 and 0x01 fetch configuration registers zero and one
// - 0x02 fetches the status register, 0x03 the monitor register
// - 0x08 and 0x09 write the data value to configuration zero and one
// - transfers run over one data line and one clock at 2.56 MHz (the divider gives 100 MHz / 38, about 2.63 MHz)
// - commands and data reach the far registers within 10 us
// - read values land in the data register within 10 us
// - command register bit 0 reads 1 while a command is in progress
// - bit 2 reports send outcome, 1 success, 0 failure
// - bit 1 reports read outcome, 1 success, 0 failure
// - outcome flags are valid only while busy is 0
// - command register resets to 0x00, bits 7 to 3 reserved
// - data register is 12 bits for sent and returned values
// - data bits 11:8 read-only command tag, bits 7:0 the value
//
// Added by the designer: the address-and-strobe port.
`include "hv_params.svh"

module hv_indirect_register_interface
  import hv_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire bus_req_s bus_req,
  output logic [31:0] rdata,
  output link_out_s link_out,
  input wire logic sdat_in,
  output logic irq
);
  localparam int HALF_CYC = `HV_HALF_CYC;
  localparam int LAT_CYC = `HV_LATENCY_CYC;
  localparam int TX_BITS = `HV_TX_BITS;

  phase_e state_reg;
  logic [4:0] div_reg;
  logic [4:0] bit_reg;
  logic [4:0] nbits_reg;
  logic sclk_reg;
  logic [12:0] tx_reg;
  logic [8:0] rx_reg;
  logic is_read_reg;
  logic [3:0] cmd_reg;
  logic [7:0] val_reg;
  logic [3:0] tag_reg;
  logic tx_ok_reg;
  logic rx_ok_reg;
  logic [1:0] stat_reg;
  logic [1:0] en_reg;
  logic [31:0] rdata_reg;
  logic sync1_reg;
  logic sync2_reg;
  logic tick;
  logic cmd_wr;
  logic cmd_valid;
  logic cmd_is_read;
  logic busy;
  logic ack;
  logic [1:0] ev;
  logic [10:0] lat_reg;

  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  assign busy = (state_reg != ST_IDLE);
  assign cmd_wr = bus_req.wr && (bus_req.addr == `HV_CMD_OFS);
  always_comb begin
    cmd_valid = 1'b1;
    cmd_is_read = 1'b0;
    case (cmd_e'(bus_req.wdata[7:0]))
      CMD_RD_CFG0, CMD_RD_CFG1, CMD_RD_STAT, CMD_RD_MON: cmd_is_read = 1'b1;
      CMD_WR_CFG0, CMD_WR_CFG1: cmd_is_read = 1'b0;
      default: cmd_valid = 1'b0;
    endcase
  end
  assign ack = rx_reg[0];
  assign tick = (div_reg == 5'(HALF_CYC - 1));

  // ----------------------------------------------------------------
  // input synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
    end else begin
      sync1_reg <= sdat_in;
      sync2_reg <= sync1_reg;
    end
  end

  // ----------------------------------------------------------------
  // serial clock divider
  // ----------------------------------------------------------------
  // half period count
  always_ff @(posedge clk_sys) begin
    if (!rstn || state_reg != ST_XFER || tick) begin
      div_reg <= 5'h0_0;
    end else begin
      div_reg <= div_reg + 5'h0_1;
    end
  end

  // ----------------------------------------------------------------
  // transfer sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      state_reg <= ST_IDLE;
      sclk_reg <= 1'b0;
      bit_reg <= 5'h0_0;
      nbits_reg <= 5'h0_0;
      tx_reg <= 13'h0_000;
      rx_reg <= 9'h0_00;
      is_read_reg <= 1'b0;
      cmd_reg <= 4'h0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          sclk_reg <= 1'b0;
          // reserved codes and busy writes ignored
          if (cmd_wr && cmd_valid) begin
            state_reg <= ST_XFER;
            bit_reg <= 5'h0_0;
            is_read_reg <= cmd_is_read;
            cmd_reg <= bus_req.wdata[3:0];
            nbits_reg <= 5'(TX_BITS + (cmd_is_read ? `HV_RX_RD_BITS : `HV_RX_WR_BITS));
            tx_reg <= {`HV_START_BIT, bus_req.wdata[3:0], cmd_is_read ? 8'h0_0 : val_reg};
            rx_reg <= 9'h0_00;
          end
        end
        ST_XFER: begin
          if (tick) begin
            sclk_reg <= !sclk_reg;
            if (!sclk_reg) begin
              // reply bits sampled on rising clock
              if (bit_reg >= 5'(TX_BITS)) begin
                rx_reg <= {rx_reg[7:0], sync2_reg};
              end
            end else begin
              tx_reg <= {tx_reg[11:0], 1'b0};
              bit_reg <= bit_reg + 5'h0_1;
              if (bit_reg == nbits_reg - 5'h0_1) begin
                state_reg <= ST_DONE;
              end
            end
          end
        end
        ST_DONE: state_reg <= ST_IDLE;
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // data register and outcome flags
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      val_reg <= 8'(`HV_DAT_RST);
      tag_reg <= 4'(`HV_DAT_RST >> `HV_TAG_LO);
    end else if (state_reg == ST_DONE) begin
      // returned byte and its command tag
      tag_reg <= cmd_reg;
      if (is_read_reg && ack) begin
        val_reg <= rx_reg[8:1];
      end
    end else if (!busy && bus_req.wr && bus_req.addr == `HV_DAT_OFS) begin
      val_reg <= bus_req.wdata[7:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      tx_ok_reg <= 1'b0;
      rx_ok_reg <= 1'b0;
    end else if (state_reg == ST_DONE) begin
      tx_ok_reg <= ack;
      rx_ok_reg <= ack && is_read_reg;
    end
  end

  // ----------------------------------------------------------------
  // interrupt status
  // ----------------------------------------------------------------
  assign ev[`HV_EV_DONE] = (state_reg == ST_DONE);
  assign ev[`HV_EV_FAIL] = (state_reg == ST_DONE) && !ack;
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      stat_reg <= `HV_IRQ_RST;
      en_reg <= `HV_IRQ_RST;
    end else begin
      if (bus_req.wr && bus_req.addr == `HV_IRQ_CLR_OFS) begin
        stat_reg <= (stat_reg & ~bus_req.wdata[1:0]) | ev;
      end else begin
        stat_reg <= stat_reg | ev;
      end
      if (bus_req.wr && bus_req.addr == `HV_IRQ_EN_OFS) begin
        en_reg <= bus_req.wdata[1:0];
      end
    end
  end
  assign irq = |(stat_reg & en_reg);

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rstn || !bus_req.rd) begin
      rdata_reg <= 32'h0000_0000;
    end else begin
      case (bus_req.addr)
        `HV_CMD_OFS: rdata_reg <= 32'({tx_ok_reg, rx_ok_reg, busy});
        `HV_DAT_OFS: rdata_reg <= 32'({tag_reg, val_reg});
        `HV_IRQ_STAT_OFS: rdata_reg <= 32'(stat_reg);
        `HV_IRQ_EN_OFS: rdata_reg <= 32'(en_reg);
        default: rdata_reg <= 32'h0000_0000;
      endcase
    end
  end
  assign rdata = rdata_reg;

  // ----------------------------------------------------------------
  // link pins
  // ----------------------------------------------------------------
  always_comb begin
    link_out.sclk = sclk_reg;
    link_out.sdat_out = tx_reg[12];
    link_out.sdat_oe_n = !(state_reg == ST_XFER && bit_reg < 5'(TX_BITS));
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rstn || !busy) begin
      lat_reg <= 11'h000;
    end else begin
      lat_reg <= lat_reg + 11'h001;
    end
  end

  a_busy_after_cmd : assert property (@(posedge clk_sys) disable iff (!rstn)
    (!busy && cmd_wr && cmd_valid) |=> busy)
    else $error("busy not raised after command");
  a_latency_bound : assert property (@(posedge clk_sys) disable iff (!rstn)
    busy |-> (lat_reg < 11'(LAT_CYC)))
    else $error("transfer exceeds latency bound");
  a_read_lands : assert property (@(posedge clk_sys) disable iff (!rstn)
    (state_reg == ST_DONE && is_read_reg && ack) |=> (val_reg == $past(rx_reg[8:1])))
    else $error("read value not stored");
  a_fail_clears : assert property (@(posedge clk_sys) disable iff (!rstn)
    (state_reg == ST_DONE && !ack) |=> (!tx_ok_reg && !rx_ok_reg))
    else $error("failure left flag set");
  a_tag_stable : assert property (@(posedge clk_sys) disable iff (!rstn)
    (state_reg == ST_XFER) |=> $stable(tag_reg))
    else $error("tag changed mid transfer");
  a_sclk_half : assert property (@(posedge clk_sys) disable iff (!rstn)
    $rose(sclk_reg) |=> sclk_reg [*8])
    else $error("serial clock high too short");
  a_idle_released : assert property (@(posedge clk_sys) disable iff (!rstn)
    (state_reg == ST_IDLE) |-> (link_out.sdat_oe_n && !link_out.sclk))
    else $error("link driven while idle");
  a_status_read : assert property (@(posedge clk_sys) disable iff (!rstn)
    (bus_req.rd && bus_req.addr == `HV_CMD_OFS) |=> (rdata[31:3] == 29'h0 && rdata[0] == $past(busy)))
    else $error("command register read wrong");
  a_flags_written : assert property (@(posedge clk_sys) disable iff (!rstn)
    (state_reg == ST_DONE) |=> (tx_ok_reg == $past(ack)))
    else $error("send flag not updated");

  a_busy_drops : assert property (@(posedge clk_sys) disable iff (!rstn)
    (state_reg == ST_DONE) |=> !busy)
    else $error("busy not cleared after completion");
  a_frame_start : assert property (@(posedge clk_sys) disable iff (!rstn)
    (!busy && cmd_wr && cmd_valid) |=> (!link_out.sdat_oe_n && link_out.sdat_out))
    else $error("frame did not open with start bit");
  a_rx_flag_write : assert property (@(posedge clk_sys) disable iff (!rstn)
    (state_reg == ST_DONE && !is_read_reg) |=> !rx_ok_reg)
    else $error("read flag set by write command");
  a_rx_flag_ack : assert property (@(posedge clk_sys) disable iff (!rstn)
    (state_reg == ST_DONE && is_read_reg) |=> (rx_ok_reg == $past(ack)))
    else $error("read flag does not follow reply");
  a_tag_update : assert property (@(posedge clk_sys) disable iff (!rstn)
    (state_reg == ST_DONE) |=> (tag_reg == $past(cmd_reg)))
    else $error("tag not taken from command");
  a_data_held : assert property (@(posedge clk_sys) disable iff (!rstn)
    (state_reg == ST_XFER) |=> $stable(val_reg))
    else $error("data changed mid transfer");
  a_sclk_low : assert property (@(posedge clk_sys) disable iff (!rstn)
    $fell(sclk_reg) |=> !sclk_reg [*8])
    else $error("serial clock low too short");
  a_reply_released : assert property (@(posedge clk_sys) disable iff (!rstn)
    (state_reg == ST_XFER && bit_reg >= 5'(TX_BITS)) |-> link_out.sdat_oe_n)
    else $error("data line driven during reply");
endmodule : hv_indirect_register_interface

//--- verification/hv_die_model.sv
// far-end die model: four indirect registers behind the serial link
// assumes start, 4 command bits, 8 data bits in, then reply bits out
module hv_die_model
  import hv_pkg::*;
(
  input wire logic rstn,
  input wire link_out_s link_out,
  input wire logic ack_ok,
  input wire logic [7:0] stat_val,
  input wire logic [7:0] mon_val,
  output logic sdat_drv,
  output logic [7:0] cfg0,
  output logic [7:0] cfg1
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [12:0] rx_sh;
  logic [8:0] reply;
  logic replying;
  int n_in;
  int n_out;
  initial begin
    sdat_drv = 1'b0;
    cfg0 = 8'h00;
    cfg1 = 8'h00;
    n_in = 0;
    replying = 1'b0;
  end
  always @(negedge rstn) begin
    n_in = 0;
    replying = 1'b0;
  end
  // line left undriven: keep it moving
  always #40 if (!replying) sdat_drv = ~sdat_drv;
  // ----------------------------------------------------------------
  // capture and decode
  // ----------------------------------------------------------------
  // sample at rise
  always @(posedge link_out.sclk) begin
    if (!link_out.sdat_oe_n && !replying) begin
      rx_sh = {rx_sh[11:0], link_out.sdat_out};
      n_in++;
      if (n_in == 13) begin
        n_in = 0;
        replying = 1'b1;
        if (rx_sh[11]) begin
          if (ack_ok && !rx_sh[8]) cfg0 = rx_sh[7:0];
          if (ack_ok && rx_sh[8]) cfg1 = rx_sh[7:0];
          reply = {ack_ok, 8'h00};
          n_out = 1;
        end else begin
          case (rx_sh[9:8])
            2'd0: reply = {cfg0, ack_ok};
            2'd1: reply = {cfg1, ack_ok};
            2'd2: reply = {stat_val, ack_ok};
            default: reply = {mon_val, ack_ok};
          endcase
          n_out = 9;
        end
      end
    end
  end
  always @(negedge link_out.sclk) begin
    if (replying) begin
      if (n_out == 0) begin
        replying = 1'b0;
        sdat_drv = ~sdat_drv;
      end else begin
        sdat_drv = reply[8];
        reply = reply << 1;
        n_out--;
      end
    end
  end
endmodule : hv_die_model

//--- verification/hv_indirect_register_interface_tb.sv
// self-checking bench for the indirect register interface
// assumes the die model answers every frame on the shared data line
`include "hv_params.svh"
module hv_indirect_register_interface_tb
  import hv_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  bus_req_s bus_req = '0;
  logic [31:0] rdata;
  link_out_s link_out;
  logic sdat_in;
  logic sdat_drv;
  logic irq;
  logic ack_ok = 1'b1;
  logic [7:0] ref_reg [4] = '{8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0] cfg0;
  logic [7:0] cfg1;
  logic [7:0] cmds [6] = '{8'h08, 8'h09, 8'h00, 8'h01, 8'h02, 8'h03};
  logic [31:0] d;
  logic [7:0] c;
  logic [7:0] v;
  int bad_count = 0;
  int n_checks = 0;
  int lat;
  always #5 clk_sys = ~clk_sys;
  assign sdat_in = link_out.sdat_oe_n ? sdat_drv : link_out.sdat_out;
  hv_indirect_register_interface i_hv_indirect_register_interface (
    .clk_sys(clk_sys), .rstn(rstn), .bus_req(bus_req), .rdata(rdata),
    .link_out(link_out), .sdat_in(sdat_in), .irq(irq));
  hv_die_model i_hv_die_model (
    .rstn(rstn), .link_out(link_out), .ack_ok(ack_ok), .stat_val(ref_reg[2]),
    .mon_val(ref_reg[3]), .sdat_drv(sdat_drv), .cfg0(cfg0), .cfg1(cfg1));
  // ----------------------------------------------------------------
  // tasks and expectations
  // ----------------------------------------------------------------
  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task test_done;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done
  task bus_wr(input logic [31:0] a, input logic [31:0] w);
    @(posedge clk_sys);
    bus_req <= '{addr: a, wdata: w, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
    bus_req.wr <= 1'b0;
  endtask : bus_wr
  task bus_rd(input logic [31:0] a);
    @(posedge clk_sys);
    bus_req <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys);
    bus_req.rd <= 1'b0;
    #1 d = rdata;
  endtask : bus_rd
  // new command only once busy reads 0
  task run(input logic [7:0] cmd);
    int i;
    bus_wr(`HV_CMD_OFS, {24'h0, cmd});
    bus_rd(`HV_CMD_OFS);
    check("busy_set", d[0], 1);
    for (i = 0; i < 600 && d[0] !== 1'b0; i++) bus_rd(`HV_CMD_OFS);
    lat = 2 * i + 4;
    if (i == 600) begin
      bad_count++;
      test_done();
    end else begin
      check("latency", lat < `HV_LATENCY_CYC, 1);
    end
  endtask : run
  function logic [31:0] exp_flags(input logic [7:0] cmd, input logic ack);
    return {29'h0, ack, ack & ~cmd[3], 1'b0};
  endfunction : exp_flags
  function logic [31:0] exp_data(input logic [7:0] cmd, input logic [7:0] val);
    return {20'h0, cmd[3:0], val};
  endfunction : exp_data
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'hb9de));
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    bus_rd(`HV_CMD_OFS);
    check("cmd_reset", d, `HV_CMD_RST);
    bus_rd(`HV_DAT_OFS);
    check("data_reset", d, `HV_DAT_RST);
    bus_rd(`HV_IRQ_STAT_OFS);
    check("irq_reset", d, 0);
    bus_rd(32'hffff_0900);
    check("unmapped", d, 0);
    $display("test reset done");
    bus_wr(`HV_IRQ_EN_OFS, 1);
    for (int k = 0; k < 12; k++) begin
      c = cmds[k % 6];
      v = (k < 2) ? {8{k[0]}} : 8'($urandom);
      ref_reg[2] = 8'($urandom);
      ref_reg[3] = 8'($urandom);
      bus_wr(`HV_DAT_OFS, {24'h0, v});
      run(c);
      if (c[3]) ref_reg[c[0]] = v;
      bus_rd(`HV_CMD_OFS);
      check("flags", d, exp_flags(c, 1'b1));
      bus_rd(`HV_DAT_OFS);
      check("data", d, exp_data(c, c[3] ? v : ref_reg[c[1:0]]));
    end
    check("cfg0", cfg0, ref_reg[0]);
    check("cfg1", cfg1, ref_reg[1]);
    check("irq_on", irq, 1);
    bus_wr(`HV_IRQ_CLR_OFS, 3);
    bus_rd(`HV_IRQ_STAT_OFS);
    check("irq_clear", d, 0);
    check("irq_off", irq, 0);
    $display("test transfers done");
    bus_wr(32'hffff_0900, 32'h0000_0009);
    bus_rd(`HV_CMD_OFS);
    check("unmapped_wr", d[0], 0);
    bus_wr(`HV_DAT_OFS, 32'h0000_0fff);
    bus_rd(`HV_DAT_OFS);
    check("tag_ro", d, exp_data(8'h03, 8'hff));
    bus_wr(`HV_IRQ_EN_OFS, 2);
    ack_ok <= 1'b0;
    for (int k = 0; k < 2; k++) begin
      c = k[0] ? 8'h08 : 8'h00;
      run(c);
      bus_rd(`HV_CMD_OFS);
      check("fail_flags", d, exp_flags(c, 1'b0));
      bus_rd(`HV_IRQ_STAT_OFS);
      check("fail_stat", d[1], 1);
      check("fail_irq", irq, 1);
    end
    check("cfg0_kept", cfg0, ref_reg[0]);
    bus_wr(`HV_IRQ_EN_OFS, 0);
    repeat (2) @(posedge clk_sys);
    #1 check("irq_masked", irq, 0);
    $display("test failures done");
    test_done();
  end
endmodule : hv_indirect_register_interface_tb
